// ==== common/fsip_consts.svh ====
// Register offsets, field positions and reset values of the interrupt block
`ifndef FSIP_CONSTS_SVH
`define FSIP_CONSTS_SVH

`define FSIP_ADDR_STATUS 8'h00
`define FSIP_ADDR_MASK 8'h01
`define FSIP_ADDR_PINCFG 8'h02

`define FSIP_STAT_CLEAR_BIT 15
`define FSIP_STAT_SECOND_BIT 6
`define FSIP_STAT_FIRST_BIT 5
`define FSIP_STAT_RSVD_HI 1'h0
`define FSIP_STAT_RSVD_LO 5'h00

`define FSIP_MASK_FIFO_BIT 8
`define FSIP_MASK_SECOND_BIT 6
`define FSIP_MASK_FIRST_BIT 5
`define FSIP_MASK_RESET 16'h01ff

`define FSIP_PCFG_DRV1_BIT 9
`define FSIP_PCFG_POL1_BIT 8
`define FSIP_PCFG_ENA0_BIT 2
`define FSIP_PCFG_DRV0_BIT 1
`define FSIP_PCFG_POL0_BIT 0
`define FSIP_PCFG_RESET 16'h0000

`define FSIP_ALT_IRQ_CODE 5'h01
`define FSIP_WORD_ZERO 16'h0000
`define FSIP_FLAGS_RESET 2'h0

`endif

// ==== common/fsip_flag_if.sv ====
// Slot event flags between register logic and flag unit
`timescale 1ns/1ps
interface fsip_flag_if #(parameter int N = 2);
  logic [N-1:0] evt;
  logic [N-1:0] clr;
  logic [N-1:0] flag;

  modport unit
  (
    input evt,
    input clr,
    output flag
  );

  modport ctrl
  (
    output evt,
    output clr,
    input flag
  );
endinterface : fsip_flag_if

// ==== common/fsip_pkg.sv ====
// Types shared by the interrupt block modules
package fsip_pkg;

  typedef logic [15:0] fsip_word_t;

  typedef enum logic [2:0]
  {
    FSIP_SEL_NONE = 3'h0,
    FSIP_SEL_STATUS = 3'h1,
    FSIP_SEL_MASK = 3'h2,
    FSIP_SEL_PINCFG = 3'h4
  } fsip_reg_sel_t;

endpackage : fsip_pkg

// ==== rtl/fsip_flags.sv ====
// Sticky slot event flags, set wins over clear
`timescale 1ns/1ps
`include "fsip_consts.svh"
module fsip_flags
(
  input wire logic clk_sys,
  input wire logic reset_n,
  fsip_flag_if.unit f
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_flag
      logic q;
      // An event in the clearing cycle is kept
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
          q <= 1'b0;
        else if (f.evt[i])
          q <= 1'b1;
        else if (f.clr[i])
          q <= 1'b0;
      end
      assign f.flag[i] = q;

      a_flag_sticky: assert property (q && !f.clr[i] |=> q)
        else $error("slot flag dropped without clear");
    end
  endgenerate

endmodule : fsip_flags

// ==== rtl/fsip_pin_drv.sv ====
// Interrupt pin polarity and drive stage
`timescale 1ns/1ps
module fsip_pin_drv
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic irq,
  input wire logic enable,
  input wire logic drive_mode,
  input wire logic polarity,
  output logic pin_o,
  output logic pin_oe_n
);

  // Pin level follows the interrupt one cycle later
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pin_o <= 1'b0;
    else
      pin_o <= irq ^ polarity;
  end

  // Floats while disabled, or idle in open-drain mode
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pin_oe_n <= 1'b1;
    else
      pin_oe_n <= !enable || (drive_mode && !irq);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_push_pull: assert property (enable && !drive_mode |=> !pin_oe_n)
    else $error("push-pull pin not driven");
  a_open_drain: assert property (enable && drive_mode && irq |=> !pin_oe_n)
    else $error("open-drain pin not driven on interrupt");

endmodule : fsip_pin_drv

// ==== rtl/fsip_top.sv ====
// FIFO status, slot event flags, interrupt mask and interrupt pin control
`timescale 1ns/1ps
`include "fsip_consts.svh"
module fsip_top
#(
  parameter int ADDR_W = 8,
  parameter int COUNT_W = 8,
  parameter int THRESH_W = 6
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [COUNT_W-1:0] fifo_byte_count,
  input wire logic [THRESH_W-1:0] fifo_word_threshold,
  input wire logic first_slot_event,
  input wire logic second_slot_event,
  input wire logic [4:0] secondary_pin_function_select,
  output logic fifo_clear,
  output logic primary_interrupt_pin_o,
  output logic primary_interrupt_pin_oe_n,
  output logic secondary_interrupt_pin_o,
  output logic secondary_interrupt_pin_oe_n
);

  fsip_pkg::fsip_reg_sel_t sel;
  fsip_pkg::fsip_word_t interrupt_mask;
  fsip_pkg::fsip_word_t interrupt_pin_config;
  fsip_pkg::fsip_word_t status_view;
  fsip_pkg::fsip_word_t next_rdata;
  logic [COUNT_W-1:0] thresh_bytes;
  logic fifo_level;
  logic irq;
  logic status_wr;
  logic sec_is_irq;

  fsip_flag_if #(.N(2)) flags ();

  // Address decode
  always_comb
  begin
    if (reg_addr == `FSIP_ADDR_STATUS)
      sel = fsip_pkg::FSIP_SEL_STATUS;
    else if (reg_addr == `FSIP_ADDR_MASK)
      sel = fsip_pkg::FSIP_SEL_MASK;
    else if (reg_addr == `FSIP_ADDR_PINCFG)
      sel = fsip_pkg::FSIP_SEL_PINCFG;
    else
      sel = fsip_pkg::FSIP_SEL_NONE;
  end

  assign status_wr = reg_wr && (sel == fsip_pkg::FSIP_SEL_STATUS);

  // Mask register, all disabled out of reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      interrupt_mask <= `FSIP_MASK_RESET;
    else if (reg_wr && sel == fsip_pkg::FSIP_SEL_MASK)
      interrupt_mask <= reg_wdata;
  end

  // Pin configuration register
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      interrupt_pin_config <= `FSIP_PCFG_RESET;
    else if (reg_wr && sel == fsip_pkg::FSIP_SEL_PINCFG)
      interrupt_pin_config <= reg_wdata;
  end

  // FIFO flush is a one-cycle command to the FIFO, not a stored bit
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      fifo_clear <= 1'b0;
    else
      fifo_clear <= status_wr && reg_wdata[`FSIP_STAT_CLEAR_BIT];
  end

  // Slot flags: index 0 first slot, index 1 second slot
  assign flags.evt = {second_slot_event, first_slot_event};
  assign flags.clr = {status_wr && reg_wdata[`FSIP_STAT_SECOND_BIT],
                      status_wr && reg_wdata[`FSIP_STAT_FIRST_BIT]};

  fsip_flags u_flags
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .f(flags.unit)
  );

  // Threshold is in words; the count is in bytes
  assign thresh_bytes = COUNT_W'({fifo_word_threshold, 1'b0});
  // Level, not sticky: drops as soon as the byte count falls to the threshold
  assign fifo_level = fifo_byte_count > thresh_bytes;

  assign irq = (fifo_level && !interrupt_mask[`FSIP_MASK_FIFO_BIT])
            || (flags.flag[1] && !interrupt_mask[`FSIP_MASK_SECOND_BIT])
            || (flags.flag[0] && !interrupt_mask[`FSIP_MASK_FIRST_BIT]);

  // Reserved status bits hold nothing, so writing ones leaves them at zero
  assign status_view = {fifo_byte_count, `FSIP_STAT_RSVD_HI, flags.flag[1], flags.flag[0],
                        `FSIP_STAT_RSVD_LO};

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = `FSIP_WORD_ZERO;
    case (sel)
      fsip_pkg::FSIP_SEL_STATUS: next_rdata = status_view;
      fsip_pkg::FSIP_SEL_MASK: next_rdata = interrupt_mask;
      fsip_pkg::FSIP_SEL_PINCFG: next_rdata = interrupt_pin_config;
      default: next_rdata = `FSIP_WORD_ZERO;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= `FSIP_WORD_ZERO;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // Primary pin: status keeps running even while the pin is disabled
  fsip_pin_drv u_primary
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .irq(irq),
    .enable(interrupt_pin_config[`FSIP_PCFG_ENA0_BIT]),
    .drive_mode(interrupt_pin_config[`FSIP_PCFG_DRV0_BIT]),
    .polarity(interrupt_pin_config[`FSIP_PCFG_POL0_BIT]),
    .pin_o(primary_interrupt_pin_o),
    .pin_oe_n(primary_interrupt_pin_oe_n)
  );

  // Other alternate functions live elsewhere; this block floats the pin for them
  assign sec_is_irq = secondary_pin_function_select == `FSIP_ALT_IRQ_CODE;

  fsip_pin_drv u_secondary
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .irq(irq),
    .enable(sec_is_irq),
    .drive_mode(interrupt_pin_config[`FSIP_PCFG_DRV1_BIT]),
    .polarity(interrupt_pin_config[`FSIP_PCFG_POL1_BIT]),
    .pin_o(secondary_interrupt_pin_o),
    .pin_oe_n(secondary_interrupt_pin_oe_n)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_flush_req;
    reg_wr && reg_addr == `FSIP_ADDR_STATUS && reg_wdata[`FSIP_STAT_CLEAR_BIT];
  endsequence

  sequence s_status_read;
    reg_rd && reg_addr == `FSIP_ADDR_STATUS;
  endsequence

  sequence s_first_clear_only;
    reg_wr && reg_addr == `FSIP_ADDR_STATUS && reg_wdata[`FSIP_STAT_FIRST_BIT]
      && !first_slot_event;
  endsequence

  sequence s_level_unmasked;
    !interrupt_mask[`FSIP_MASK_FIFO_BIT]
      && fifo_byte_count > COUNT_W'({fifo_word_threshold, 1'b0});
  endsequence

  sequence s_primary_push_pull;
    interrupt_pin_config[`FSIP_PCFG_ENA0_BIT] && !interrupt_pin_config[`FSIP_PCFG_DRV0_BIT];
  endsequence

  sequence s_second_unmasked;
    flags.flag[1] && !interrupt_mask[`FSIP_MASK_SECOND_BIT];
  endsequence

  sequence s_first_unmasked;
    flags.flag[0] && !interrupt_mask[`FSIP_MASK_FIRST_BIT];
  endsequence

  sequence s_second_clear_only;
    reg_wr && reg_addr == `FSIP_ADDR_STATUS && reg_wdata[`FSIP_STAT_SECOND_BIT]
      && !second_slot_event;
  endsequence

  sequence s_mask_write;
    reg_wr && reg_addr == `FSIP_ADDR_MASK;
  endsequence

  sequence s_pincfg_write;
    reg_wr && reg_addr == `FSIP_ADDR_PINCFG;
  endsequence

  // Back-to-back flush requests legally keep the pulse up
  a_fifo_flush: assert property (s_flush_req |=> fifo_clear ##1
    (!fifo_clear || $past(status_wr && reg_wdata[`FSIP_STAT_CLEAR_BIT])))
    else $error("FIFO flush pulse missing or too long");

  a_flush_cause: assert property (fifo_clear |-> $past(status_wr))
    else $error("FIFO flush without a status write");

  a_count_read: assert property (s_status_read |=>
    reg_rdata[15:8] == $past(fifo_byte_count))
    else $error("status read lost the byte count");

  a_rsvd_zero: assert property (s_status_read |=>
    reg_rdata[7] == 1'b0 && reg_rdata[4:0] == 5'h00)
    else $error("reserved status bits not zero");

  a_flag_read: assert property (s_status_read |=>
    reg_rdata[6:5] == $past({flags.flag[1], flags.flag[0]}))
    else $error("status read lost the slot flags");

  a_second_set: assert property (second_slot_event |=> flags.flag[1])
    else $error("second slot event not flagged");

  a_first_set: assert property (first_slot_event |=> flags.flag[0])
    else $error("first slot event not flagged");

  a_first_clear: assert property (s_first_clear_only |=> !flags.flag[0])
    else $error("write one did not clear first slot flag");

  a_second_clear: assert property (s_second_clear_only |=> !flags.flag[1])
    else $error("write one did not clear second slot flag");

  a_level_pin: assert property (s_level_unmasked ##0 s_primary_push_pull |=>
    primary_interrupt_pin_o == !interrupt_pin_config[`FSIP_PCFG_POL0_BIT])
    else $error("FIFO level did not reach primary pin");

  a_all_masked: assert property (interrupt_mask[`FSIP_MASK_FIFO_BIT]
    && interrupt_mask[`FSIP_MASK_SECOND_BIT]
    && interrupt_mask[`FSIP_MASK_FIRST_BIT] |-> !irq)
    else $error("interrupt raised while all sources masked");

  a_second_irq: assert property (s_second_unmasked |-> irq)
    else $error("unmasked second slot flag raised no interrupt");

  a_first_irq: assert property (s_first_unmasked |-> irq)
    else $error("unmasked first slot flag raised no interrupt");

  a_mask_store: assert property (s_mask_write |=>
    interrupt_mask == $past(reg_wdata))
    else $error("mask write not stored");

  a_pincfg_store: assert property (s_pincfg_write |=>
    interrupt_pin_config == $past(reg_wdata))
    else $error("pin config write not stored");

  a_primary_pol: assert property (interrupt_pin_config[`FSIP_PCFG_ENA0_BIT] |=>
    primary_interrupt_pin_o == $past(irq ^ interrupt_pin_config[`FSIP_PCFG_POL0_BIT]))
    else $error("primary pin polarity wrong");

  a_secondary_pol: assert property (sec_is_irq |=>
    secondary_interrupt_pin_o == $past(irq ^ interrupt_pin_config[`FSIP_PCFG_POL1_BIT]))
    else $error("secondary pin polarity wrong");

  a_primary_od: assert property (interrupt_pin_config[`FSIP_PCFG_DRV0_BIT] && !irq
    |=> primary_interrupt_pin_oe_n)
    else $error("idle open-drain primary pin is driven");

  a_secondary_od: assert property (interrupt_pin_config[`FSIP_PCFG_DRV1_BIT] && !irq
    |=> secondary_interrupt_pin_oe_n)
    else $error("idle open-drain secondary pin is driven");

  a_primary_float: assert property (!interrupt_pin_config[`FSIP_PCFG_ENA0_BIT] |=>
    primary_interrupt_pin_oe_n)
    else $error("disabled primary pin is driven");

  a_secondary_alt: assert property (!sec_is_irq |=> secondary_interrupt_pin_oe_n)
    else $error("secondary pin driven without interrupt function");

  a_level_drops: assert property (!fifo_level && !flags.flag[0]
    && !flags.flag[1] |-> !irq)
    else $error("interrupt held with no active source");

endmodule : fsip_top

// ==== tb/fsip_fifo_model.sv ====
// Byte counter model of the external sample FIFO
`timescale 1ns/1ps
module fsip_fifo_model
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic fill,
  input wire logic fifo_clear,
  output logic [7:0] fifo_byte_count
);
  // Flush wins over a fill in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      fifo_byte_count <= 8'h00;
    else if (fifo_clear)
      fifo_byte_count <= 8'h00;
    else if (fill)
      fifo_byte_count <= fifo_byte_count + 8'h02;
  end
endmodule : fsip_fifo_model

// ==== tb/tb.sv ====
// Self-checking bench for the interrupt status and pin block
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0] cnt;
  logic [5:0] thr = 6'h00;
  logic ev_a = 1'b0;
  logic ev_b = 1'b0;
  logic [4:0] sel = 5'h00;
  logic fifo_clear;
  logic fill = 1'b0;
  logic p_o, p_oe_n, s_o, s_oe_n;
  logic [3:0] pins_seen;
  int n_mismatch = 0;
  int checked = 0;

  // Floating pin shows as 2'b10 whatever its data level
  assign pins_seen = {p_oe_n, p_o & ~p_oe_n, s_oe_n, s_o & ~s_oe_n};

  fsip_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fifo_byte_count(cnt), .fifo_word_threshold(thr), .first_slot_event(ev_a),
    .second_slot_event(ev_b), .secondary_pin_function_select(sel),
    .fifo_clear(fifo_clear), .primary_interrupt_pin_o(p_o),
    .primary_interrupt_pin_oe_n(p_oe_n), .secondary_interrupt_pin_o(s_o),
    .secondary_interrupt_pin_oe_n(s_oe_n));

  fsip_fifo_model i_fifo (.clk_sys(clk_sys), .reset_n(reset_n), .fill(fill),
    .fifo_clear(fifo_clear), .fifo_byte_count(cnt));

  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chkpin(input string what, input logic [3:0] exp);
    checked++;
    if (pins_seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, pins_seen);
    end
  endtask : chkpin

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  // Read data is registered, so sample one extra cycle later
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    chk16(what, exp, reg_rdata);
  endtask : rdchk

  task automatic pulse(input logic second);
    @(negedge clk_sys);
    if (second)
      ev_b = 1'b1;
    else
      ev_a = 1'b1;
    @(negedge clk_sys);
    ev_a = 1'b0;
    ev_b = 1'b0;
  endtask : pulse

  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask : settle

  function automatic logic [1:0] pexp(input logic en, dv, pl, q);
    return (en && (!dv || q)) ? {1'b0, q ^ pl} : 2'b10;
  endfunction : pexp

  task automatic t_reset;
    chkpin("pins after reset", 4'b1010);
    rdchk(8'h01, 16'h01ff, "mask after reset");
    rdchk(8'h02, 16'h0000, "pin config after reset");
    rdchk(8'h00, 16'h0000, "status after reset");
    wr(8'h07, 16'hffff);
    rdchk(8'h07, 16'h0000, "unmapped read");
    rdchk(8'h01, 16'h01ff, "mask after unmapped write");
  endtask : t_reset

  task automatic t_flags;
    pulse(1'b0);
    rdchk(8'h00, 16'h0020, "first flag set, pin off");
    wr(8'h00, 16'h0000);
    rdchk(8'h00, 16'h0020, "flag after zero write");
    pulse(1'b1);
    rdchk(8'h00, 16'h0060, "both flags set");
    wr(8'h00, 16'h00bf);
    rdchk(8'h00, 16'h0040, "first flag cleared only");
    wr(8'h00, 16'h00ff);
    rdchk(8'h00, 16'h0000, "all cleared");
  endtask : t_flags

  task automatic t_fifo;
    wr(8'h01, 16'h00ff);
    wr(8'h02, 16'h0004);
    thr = 6'h02;
    repeat (3)
    begin
      @(negedge clk_sys);
      fill = 1'b1;
      @(negedge clk_sys);
      fill = 1'b0;
    end
    rdchk(8'h00, 16'h0600, "byte count");
    chkpin("level above threshold", 4'b0110);
    thr = 6'h03;
    settle();
    chkpin("level equal threshold", 4'b0010);
    thr = 6'h02;
    wr(8'h01, 16'h01ff);
    settle();
    chkpin("level masked", 4'b0010);
    wr(8'h01, 16'h00ff);
    settle();
    chkpin("level unmasked again", 4'b0110);
    wr(8'h00, 16'h8000);
    settle();
    chkpin("level after flush", 4'b0010);
    rdchk(8'h00, 16'h0000, "count after flush");
  endtask : t_fifo

  // Every enable, drive and polarity mix with the interrupt off then on
  task automatic t_pins;
    logic en, dv, pl, q;
    wr(8'h01, 16'h019f);
    for (int i = 0; i < 16; i++)
    begin
      en = i[0];
      dv = i[1];
      pl = i[2];
      q = i[3];
      @(negedge clk_sys);
      sel = en ? 5'h01 : 5'h02;
      wr(8'h02, {6'h00, dv, pl, 5'h00, en, dv, pl});
      if (q)
        pulse(1'b0);
      else
        wr(8'h00, 16'h00bf);
      settle();
      chkpin("pin mode", {pexp(en, dv, pl, q), pexp(en, dv, pl, q)});
    end
    wr(8'h01, 16'h01ff);
    settle();
    chkpin("slot masked", 4'b1010);
  endtask : t_pins

  // Second slot alone unmasked; first slot flag set but masked
  task automatic t_second;
    wr(8'h00, 16'h00ff);
    wr(8'h01, 16'h01bf);
    wr(8'h02, 16'h0004);
    pulse(1'b1);
    pulse(1'b0);
    settle();
    chkpin("second slot unmasked", 4'b0101);
    rdchk(8'h00, 16'h0060, "both flags before clear");
    wr(8'h00, 16'h00df);
    settle();
    chkpin("first slot masked", 4'b0000);
    rdchk(8'h00, 16'h0020, "second flag cleared only");
  endtask : t_second

  initial
  begin
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_flags();
    t_fifo();
    t_pins();
    t_second();
    print_verdict();
  end

  // Tests need well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb
